// [tb/dwp_asserts.sv]
// Port checker for the dual wiper two-wire slave
`timescale 1ns/1ps
module dwp_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wiper_write_zero,
  input wire logic wiper_write_one,
  input wire logic [7:0] wiper_write_data,
  input wire logic [7:0] wiper_position_zero,
  input wire logic [7:0] wiper_position_one,
  input wire logic rx_byte_valid,
  input wire logic rx_first_data,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Stop: SDA rises while SCL stays high
  sequence stop_seq;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence released_seq;
    !busy && !sda_oe;
  endsequence
  a_pin_low_only: assert property (sda_out == 1'b0) else $error("sda_out high");
  a_load_wiper_zero: assert property (wiper_write_zero |=> wiper_position_zero == $past(wiper_write_data))
    else $error("wiper0 load");
  a_load_wiper_one: assert property (wiper_write_one |=> wiper_position_one == $past(wiper_write_data))
    else $error("wiper1 load");
  a_hold_wiper_zero: assert property (!wiper_write_zero |=> $stable(wiper_position_zero))
    else $error("wiper0 moved");
  a_reset_clear: assert property (disable iff (1'b0) reset |=> (wiper_position_zero == 8'h00 &&
    wiper_position_one == 8'h00) and released_seq) else $error("reset state");
  a_stop_release: assert property (stop_seq |-> ##[1:3] released_seq) else $error("stop not idle");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
  a_first_with_valid: assert property (rx_first_data |-> rx_byte_valid) else $error("first alone");
  a_valid_pulse: assert property (rx_byte_valid |=> !rx_byte_valid) else $error("valid long");
  a_idle_released: assert property (!busy && !$past(busy) |-> !sda_oe) else $error("idle drive");
endmodule
bind dwp_slave dwp_chk u_chk (.*);

// [tb/dwp_mst.sv]
// Two-wire bus master model
`timescale 1ns/1ps
module dwp_mst (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves only with SCL low
  task automatic bit_io(input logic b, output logic r);
    @(posedge ref_clk) sda_low <= ~b;
    wt(4);
    scl <= 1'b1;
    wt(3);
    #1 r = sda;
    wt(2);
    scl <= 1'b0;
    wt(3);
  endtask
  task automatic start();
    @(posedge ref_clk) sda_low <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(3);
  endtask
  task automatic stop();
    @(posedge ref_clk) sda_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b0;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ma, ack);
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the dual wiper slave
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] sel = 3'h5;
  logic wz = 1'b0;
  logic wo = 1'b0;
  logic [7:0] wd = 8'h00;
  logic sda_oe, sda_out, scl, m_low, busy, rxv, rxf, a;
  logic [7:0] p0, p1, rxb, r;
  // Wrong select, wrong type code, wrong select
  logic [7:0] bad [3] = '{{dwp_pkg::DEVICE_TYPE_CODE, 4'h9}, {~dwp_pkg::DEVICE_TYPE_CODE, 4'hB},
    {dwp_pkg::DEVICE_TYPE_CODE, 4'hF}};
  int error_cnt = 0;
  int cmp_count = 0;
  int first_cnt = 0;
  int valid_cnt = 0;
  // Pull-up resolves the open-drain line
  wire logic sda = ~(m_low | sda_oe);
  initial forever #5 ref_clk = ~ref_clk;
  dwp_mst u_mst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));
  dwp_slave u_dut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_bit0(sel[0]), .device_select_bit1(sel[1]), .device_select_bit2(sel[2]),
    .wiper_write_zero(wz), .wiper_write_one(wo), .wiper_write_data(wd), .wiper_position_zero(p0),
    .wiper_position_one(p1), .rx_byte_valid(rxv), .rx_byte(rxb), .rx_first_data(rxf), .busy(busy));
  // Pulse counter, since the flag lasts one cycle
  always @(posedge ref_clk) begin
    if (rxf === 1'b1) first_cnt++;
    if (rxv === 1'b1) valid_cnt++;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic load(input logic [7:0] v0, input logic [7:0] v1);
    @(posedge ref_clk) {wz, wd} <= {1'b1, v0};
    @(posedge ref_clk) {wz, wo, wd} <= {2'b01, v1};
    @(posedge ref_clk) wo <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("wiper0 rst", 8'h00, p0);
    chk("wiper1 rst", 8'h00, p1);
    load(8'hA5, 8'h3C);
    chk("wiper0", 8'hA5, p0);
    chk("wiper1", 8'h3C, p1);
    u_mst.start();
    u_mst.xfer({dwp_pkg::DEVICE_TYPE_CODE, sel, 1'b1}, 1'b1, r, a);
    chk("rd ctl ack", 8'h00, {7'h00, a});
    u_mst.xfer(8'hFF, 1'b0, r, a);
    chk("rd byte0", 8'hA5, r);
    u_mst.xfer(8'hFF, 1'b1, r, a);
    chk("rd byte1", 8'h3C, r);
    u_mst.stop();
    chk("busy", 8'h00, {7'h00, busy});
    $display("test read_both done");
    load(8'hFF, 8'h00);
    u_mst.start();
    u_mst.xfer({dwp_pkg::DEVICE_TYPE_CODE, sel, 1'b1}, 1'b1, r, a);
    u_mst.xfer(8'hFF, 1'b1, r, a);
    chk("rd high end", 8'hFF, r);
    chk("sda released", 8'h01, {7'h00, sda});
    u_mst.start();
    u_mst.xfer({dwp_pkg::DEVICE_TYPE_CODE, sel, 1'b0}, 1'b1, r, a);
    chk("wr ctl ack", 8'h00, {7'h00, a});
    u_mst.xfer(8'hC3, 1'b1, r, a);
    chk("wr ack", 8'h00, {7'h00, a});
    chk("rx byte", 8'hC3, rxb);
    u_mst.xfer(8'h81, 1'b1, r, a);
    chk("wr ack2", 8'h00, {7'h00, a});
    chk("rx byte2", 8'h81, rxb);
    chk("first flags", 8'h01, first_cnt[7:0]);
    chk("valid pulses", 8'h02, valid_cnt[7:0]);
    u_mst.stop();
    $display("test restart_write done");
    for (int i = 0; i < 3; i++) begin
      u_mst.start();
      u_mst.xfer(bad[i], 1'b1, r, a);
      chk("no ack", 8'h01, {7'h00, a});
      u_mst.xfer(8'h00, 1'b1, r, a);
      chk("ignored", 8'h01, {7'h00, a});
      u_mst.stop();
    end
    sel <= 3'h2;
    u_mst.start();
    u_mst.xfer({dwp_pkg::DEVICE_TYPE_CODE, sel, 1'b1}, 1'b1, r, a);
    chk("sel ack", 8'h00, {7'h00, a});
    u_mst.xfer(8'hFF, 1'b1, r, a);
    chk("sel rd", 8'hFF, r);
    u_mst.stop();
    $display("test select done");
    close_out();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule

// [verilog/dwp_line_if.sv]
// Bus condition events passed from the line watcher to the serial engine
`timescale 1ns/1ps
interface dwp_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_seen;
  logic stop_seen;
  modport watcher (output scl_rise, output scl_fall, output sda_level, output start_seen, output stop_seen);
  modport engine (input scl_rise, input scl_fall, input sda_level, input start_seen, input stop_seen);
endinterface

// [verilog/dwp_line_watch.sv]
// Oversampling edge and START/STOP detector for SCL and SDA
`timescale 1ns/1ps
module dwp_line_watch (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  dwp_line_if.watcher line
);
  logic scl_q;
  logic sda_q;

  // Previous line levels; reset to idle-high so no false edge at release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Edge and condition pulses, one cycle each; SDA level passed straight through
  always_comb begin
    line.scl_rise = scl_in & ~scl_q;
    line.scl_fall = ~scl_in & scl_q;
    line.sda_level = sda_in;
    line.start_seen = scl_in & scl_q & sda_q & ~sda_in;
    line.stop_seen = scl_in & scl_q & ~sda_q & sda_in;
  end
endmodule

// [verilog/dwp_pkg.sv]
// Shared constants for the dual wiper two-wire slave
package dwp_pkg;
  // Device-type code of the control byte; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] WIPER_HIGH_END = 8'hFF;
  localparam logic [7:0] WIPER_LOW_END = 8'h00;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] LAST_BIT_INDEX = 4'h7;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SELECT_MSB = 3;
  localparam int SELECT_LSB = 1;
  localparam int DIR_BIT = 0;
  typedef enum logic [1:0] {
    DWP_IDLE,
    DWP_RECEIVE,
    DWP_TRANSMIT,
    DWP_IGNORE
  } dwp_state_e;
endpackage

// [verilog/dwp_slave.sv]
// Two-wire slave front end holding two 8-bit wiper registers
//
// Operation
// - One 8-bit wiper register per potentiometer; FFh high end, 00h low end.
// - Both wipers clear to 00h at power-up reset; nothing retained.
// - Device is slave only; master makes clocks, START and STOP.
// - SDA changes only with SCL low; change under SCL high is control.
// - SDA fall under SCL high is START; rise is STOP.
// - Eight data bits per byte, then an acknowledge bit from the receiver.
// - Bytes shift most significant bit first.
// - Acknowledger holds SDA low through the whole ninth clock high.
// - Master not-acknowledges last read byte; device then releases SDA.
// - First byte after START is control: type code plus three select bits.
// - Control byte bit zero: one means read, zero means write.
// - Acknowledge control only on full match, then receive or transmit.
// - In receive mode every byte from master is acknowledged.
// - Repeated START ends transfer and decodes a new control byte.
// - START and STOP recognised in both receive and transmit modes.
// - Read returns wiper zero, then wiper one if master acknowledges.
`timescale 1ns/1ps
module dwp_slave (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  input wire logic device_select_bit2,
  input wire logic wiper_write_zero,
  input wire logic wiper_write_one,
  input wire logic [7:0] wiper_write_data,
  output logic [7:0] wiper_position_zero,
  output logic [7:0] wiper_position_one,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_first_data,
  output logic busy
);
  dwp_line_if line ();
  dwp_pkg::dwp_state_e state;
  logic control_phase;
  logic [3:0] bit_count;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic read_second;
  logic ack_drive;
  logic first_data_pending;
  logic [2:0] select_bits;
  logic [7:0] next_byte;
  logic match;

  dwp_line_watch u_watch (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line)
  );

  // Control byte decode on the byte about to complete
  always_comb begin
    select_bits = {device_select_bit2, device_select_bit1, device_select_bit0};
    next_byte = {shift_in[6:0], line.sda_level};
    match = (next_byte[dwp_pkg::TYPE_MSB:dwp_pkg::TYPE_LSB] == dwp_pkg::DEVICE_TYPE_CODE) &&
            (next_byte[dwp_pkg::SELECT_MSB:dwp_pkg::SELECT_LSB] == select_bits);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wiper_position_zero <= dwp_pkg::WIPER_RESET;
      wiper_position_one <= dwp_pkg::WIPER_RESET;
    end else begin
      if (wiper_write_zero) begin
        wiper_position_zero <= wiper_write_data;
      end
      if (wiper_write_one) begin
        wiper_position_one <= wiper_write_data;
      end
    end
  end

  // Serial engine: sampled on SCL rise, driven on SCL fall
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= dwp_pkg::DWP_IDLE;
      control_phase <= 1'b0;
      bit_count <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      read_second <= 1'b0;
      ack_drive <= 1'b0;
      first_data_pending <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_first_data <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      rx_first_data <= 1'b0;
      if (line.stop_seen) begin
        state <= dwp_pkg::DWP_IDLE;
        ack_drive <= 1'b0;
        control_phase <= 1'b0;
      end else if (line.start_seen) begin
        state <= dwp_pkg::DWP_RECEIVE;
        control_phase <= 1'b1;
        bit_count <= 4'h0;
        ack_drive <= 1'b0;
        read_second <= 1'b0;
      end else begin
        unique case (state)
          dwp_pkg::DWP_IDLE, dwp_pkg::DWP_IGNORE: begin
            ack_drive <= 1'b0;
          end
          dwp_pkg::DWP_RECEIVE: begin
            if (line.scl_rise && bit_count <= dwp_pkg::LAST_BIT_INDEX) begin
              shift_in <= next_byte;
              bit_count <= bit_count + 4'h1;
              if (bit_count == dwp_pkg::LAST_BIT_INDEX && !control_phase) begin
                rx_byte_valid <= 1'b1;
                rx_byte <= next_byte;
                rx_first_data <= first_data_pending;
                first_data_pending <= 1'b0;
              end
              if (bit_count == dwp_pkg::LAST_BIT_INDEX && control_phase && !match) begin
                state <= dwp_pkg::DWP_IGNORE;
              end
            end else if (line.scl_fall && bit_count == dwp_pkg::ACK_BIT_INDEX && !ack_drive) begin
              ack_drive <= 1'b1;
            end else if (line.scl_fall && bit_count == dwp_pkg::ACK_BIT_INDEX && ack_drive) begin
              ack_drive <= 1'b0;
              bit_count <= 4'h0;
              if (control_phase) begin
                control_phase <= 1'b0;
                first_data_pending <= 1'b1;
                if (shift_in[dwp_pkg::DIR_BIT]) begin
                  state <= dwp_pkg::DWP_TRANSMIT;
                  shift_out <= wiper_position_zero;
                  read_second <= 1'b0;
                end
              end
            end
          end
          dwp_pkg::DWP_TRANSMIT: begin
            if (line.scl_fall && bit_count < dwp_pkg::LAST_BIT_INDEX) begin
              shift_out <= {shift_out[6:0], 1'b0};
              bit_count <= bit_count + 4'h1;
            end else if (line.scl_fall && bit_count == dwp_pkg::LAST_BIT_INDEX) begin
              bit_count <= dwp_pkg::ACK_BIT_INDEX;
            end else if (line.scl_fall && bit_count == dwp_pkg::ACK_BIT_INDEX && read_second) begin
              // second byte waits for SCL low
              bit_count <= 4'h0;
            end else if (line.scl_rise && bit_count == dwp_pkg::ACK_BIT_INDEX) begin
              if (!line.sda_level && !read_second) begin
                // second byte on acknowledge
                // Driver stays released until the ninth clock falls
                read_second <= 1'b1;
                shift_out <= wiper_position_one;
              end else begin
                state <= dwp_pkg::DWP_IGNORE;
              end
            end
          end
        endcase
      end
    end
  end

  // slave only, no SCL drive
  // Open-drain SDA: output fixed low, enable pulls the line
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      busy <= (state != dwp_pkg::DWP_IDLE);
      if (state == dwp_pkg::DWP_TRANSMIT && bit_count <= dwp_pkg::LAST_BIT_INDEX && !line.stop_seen &&
          !line.start_seen) begin
        sda_oe <= ~shift_out[7];
      end else begin
        sda_oe <= ack_drive && state == dwp_pkg::DWP_RECEIVE;
      end
    end
  end
endmodule
